// ===== shunt_power_calc_engine_bench.sv
`timescale 1ns/1ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, x); end end
module shunt_power_calc_engine_bench;
  import spce_pkg::*;
  typedef struct {logic [15:0] sh, rl, sc, cur, pwr;} spce_row_t;
  logic        clk, rst_n, sv, rv, wr, rd, err, restart, busy;
  logic [2:0]  addr;
  logic [15:0] sd, rdat, wdata, rdata, setup, q;
  logic        e;
  int          n_fail, cmp_count;
  // Shunt, rail, scale, expected current, expected power
  spce_row_t   rows [4] = '{
    '{16'h1F40, 16'h2570, 16'h0A00, 16'h2710, 16'h12B8},
    '{16'hE0C0, 16'h2570, 16'h0A00, 16'hD8F0, 16'hED48},
    '{16'h7FFF, 16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h7FFF},
    '{16'h8000, 16'h0100, 16'hFFFF, 16'h8000, 16'hFE5D}};

  spce_calc_engine dut (.ref_clk_in(clk), .reset_n_in(rst_n), .shunt_valid_in(sv),
    .shunt_data_in(sd), .rail_valid_in(rv), .rail_data_in(rdat), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_err_out(err), .setup_out(setup), .restart_out(restart), .busy_out(busy));
  spce_host_model host (.ref_clk_in(clk), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_err_in(err));

  // ==========================================================
  // Clock, watchdog and verdict
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #500000;
    n_fail++;
    test_done();
  end
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One shunt then one rail conversion, then a bounded wait for the result
  task automatic conv(input logic [15:0] s, input logic [15:0] r);
    @(posedge clk);
    #2;
    sv = 1'b1;
    sd = s;
    @(posedge clk);
    #2;
    sv = 1'b0;
    sd = ~s;
    rv = 1'b1;
    rdat = r;
    @(posedge clk);
    #2;
    rv = 1'b0;
    rdat = ~r;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #2;
    end
    `CHK(busy, 1'b0)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {sv, rv} = 2'b00;
    sd = 16'h0000;
    rdat = 16'h0000;
    repeat (6) @(posedge clk);
    #2;
    rst_n = 1'b1;
    `CHK(setup, 16'h4127)
    host.access(1'b0, 3'h5, 16'h0000, q, e);
    `CHK(q, 16'h0000)
    // Uncalibrated: raw readings only, results stay zero
    conv(16'h1F40, 16'h2570);
    host.access(1'b0, 3'h4, 16'h0000, q, e);
    `CHK(q, 16'h0000)
    host.access(1'b0, 3'h3, 16'h0000, q, e);
    `CHK(q, 16'h0000)
    host.access(1'b0, 3'h1, 16'h0000, q, e);
    `CHK(q, 16'h1F40)
    // Table rows: sign, saturation and rail top bit
    foreach (rows[i]) begin
      host.access(1'b1, 3'h5, rows[i].sc, q, e);
      `CHK(e, 1'b0)
      conv(rows[i].sh, rows[i].rl);
      host.access(1'b0, 3'h4, 16'h0000, q, e);
      `CHK(q, rows[i].cur)
      host.access(1'b0, 3'h3, 16'h0000, q, e);
      `CHK(q, rows[i].pwr)
      host.access(1'b0, 3'h2, 16'h0000, q, e);
      `CHK(q, rows[i].rl & 16'h7FFF)
      host.access(1'b0, 3'h1, 16'h0000, q, e);
      `CHK(q, rows[i].sh)
    end
    // System correction of the scale factor
    q = host.corrected(16'h0A00, 10100, 10000);
    `CHK(q, 16'h0A19)
    host.access(1'b1, 3'h5, q, q, e);
    conv(16'h1F40, 16'h2570);
    host.access(1'b0, 3'h4, 16'h0000, q, e);
    `CHK(q, 16'h2771)
    host.access(1'b0, 3'h3, 16'h0000, q, e);
    `CHK(q, 16'h12E6)
    // Refused accesses: read-only result, unmapped offset
    host.access(1'b1, 3'h3, 16'h1234, q, e);
    `CHK(e, 1'b1)
    host.access(1'b0, 3'h3, 16'h0000, q, e);
    `CHK(q, 16'h12E6)
    host.access(1'b0, 3'h6, 16'h0000, q, e);
    `CHK(e, 1'b1)
    `CHK(q, 16'h0000)
    // Soft reset through the setup word, then the host programs again
    host.access(1'b1, 3'h0, 16'h8127, q, e);
    `CHK(restart, 1'b1)
    host.access(1'b0, 3'h5, 16'h0000, q, e);
    `CHK(q, 16'h0000)
    host.access(1'b0, 3'h0, 16'h0000, q, e);
    `CHK(q, 16'h4127)
    host.access(1'b1, 3'h5, host.scale_of(0.001, 0.002), q, e);
    conv(16'h1F40, 16'h2570);
    host.access(1'b0, 3'h4, 16'h0000, q, e);
    `CHK(q, 16'h2710)
    // Second power-on reset in mid-run clears the scale factor
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    rst_n = 1'b1;
    host.access(1'b0, 3'h5, 16'h0000, q, e);
    `CHK(q, 16'h0000)
    test_done();
  end
endmodule // shunt_power_calc_engine_bench

// ===== spce_calc_engine.sv
`timescale 1ns/1ps
`include "spce_params.svh"
// ==========================================================
// Current and power calculation engine with its register bank
module spce_calc_engine
  import spce_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // Conversion results from the measurement sequencer
  input  wire logic        shunt_valid_in,
  input  wire logic [15:0] shunt_data_in,
  input  wire logic        rail_valid_in,
  input  wire logic [15:0] rail_data_in,
  // Register port from the serial bus engine
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [2:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic [15:0]      reg_rdata_out,
  output logic             reg_err_out,
  // Sequencer control
  output logic [15:0]      setup_out,
  output logic             restart_out,
  output logic             busy_out
);
  // ==========================================================
  // Arithmetic helpers
  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    if (v > `SPCE_SAT_MAX)
      sat16 = `SPCE_SAT_HI16;
    else if (v < `SPCE_SAT_MIN)
      sat16 = `SPCE_SAT_LO16;
    else
      sat16 = v[15:0];
  endfunction

  function automatic logic [47:0] mag48(input logic signed [47:0] v);
    mag48 = v[47] ? 48'(-v) : v;
  endfunction

  // ==========================================================
  // State
  spce_state_t st_q, st_d;
  spce_word_t  setup_q, setup_d, shunt_q, shunt_d, rail_q, rail_d;
  spce_word_t  power_q, power_d, cur_q, cur_d, scale_q, scale_d;
  spce_word_t  rdata_q, rdata_d;
  logic        err_q, err_d, restart_q, restart_d;
  logic        neg_q, neg_d, div_go_q, div_go_d;
  logic        busy_q, busy_d;
  logic [47:0] dvd_q, dvd_d;
  logic        div_done;
  logic [47:0] div_quot;
  logic signed [47:0] cur_prod, cur_shift, pwr_prod, pwr_signed;

  // Products: shunt times scale, then current times bus
  assign cur_prod   = 48'(signed'(shunt_q)) * 48'(signed'({1'b0, scale_q}));
  assign cur_shift  = cur_prod >>> `SPCE_CUR_SHIFT;
  assign pwr_prod   = 48'(signed'(cur_q)) * 48'(signed'({1'b0, rail_q}));
  assign pwr_signed = neg_q ? 48'(-signed'(div_quot)) : signed'(div_quot);

  spce_divider u_div (
    .ref_clk_in  (ref_clk_in),
    .reset_n_in  (reset_n_in),
    .start_in    (div_go_q),
    .dividend_in (dvd_q),
    .divisor_in  (`SPCE_PWR_DIV),
    .done_out    (div_done),
    .quot_out    (div_quot)
  );

  // ==========================================================
  // Next-state: registers, calculation sequence and reads
  always_comb begin
    st_d      = st_q;
    setup_d   = setup_q;
    shunt_d   = shunt_q;
    rail_d    = rail_q;
    power_d   = power_q;
    cur_d     = cur_q;
    scale_d   = scale_q;
    rdata_d   = rdata_q;
    err_d     = 1'b0;
    restart_d = 1'b0;
    neg_d     = neg_q;
    div_go_d  = 1'b0;
    dvd_d     = dvd_q;
    // New conversions land unscaled
    if (shunt_valid_in)
      shunt_d = shunt_data_in;
    if (rail_valid_in)
      rail_d = {1'b0, rail_data_in[14:0]};
    // Calculation sequence, started by a bus conversion that arrives while idle
    unique case (st_q)
      SPCE_IDLE: begin
        if (rail_valid_in)
          st_d = SPCE_CUR;
      end
      SPCE_CUR: begin
        cur_d    = (scale_q == `SPCE_ZERO16) ? `SPCE_ZERO16 : sat16(cur_shift);
        st_d     = SPCE_DIV;
        div_go_d = 1'b0;
      end
      SPCE_DIV: begin
        st_d     = SPCE_DONE;
        neg_d    = pwr_prod[47];
        dvd_d    = mag48(pwr_prod); // truncation toward zero via magnitude
        div_go_d = 1'b1;
      end
      SPCE_DONE: begin
        if (div_done) begin
          power_d = (scale_q == `SPCE_ZERO16) ? `SPCE_ZERO16 : sat16(pwr_signed);
          st_d    = SPCE_IDLE;
        end
      end
    endcase
    // Register writes; a reset bit restores the power-on values of setup, readings, results, scale and state
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `SPCE_OFS_SETUP: begin
          setup_d   = reg_wdata_in;
          setup_d[`SPCE_RST_BIT]   = 1'b0; // self-clearing
          setup_d[`SPCE_FIXED_BIT] = 1'b1;
          restart_d = 1'b1;
          if (reg_wdata_in[`SPCE_RST_BIT]) begin
            setup_d = `SPCE_SETUP_RST;
            shunt_d = `SPCE_ZERO16;
            rail_d  = `SPCE_ZERO16;
            power_d = `SPCE_ZERO16;
            cur_d   = `SPCE_ZERO16;
            scale_d = `SPCE_ZERO16;
            st_d    = SPCE_IDLE;
          end
        end
        `SPCE_OFS_SCALE: begin
          scale_d = reg_wdata_in;
          // Clearing the factor clears both results at once, so a stale
          // result never survives into an uncalibrated state
          if (reg_wdata_in == `SPCE_ZERO16) begin
            cur_d   = `SPCE_ZERO16;
            power_d = `SPCE_ZERO16;
          end
        end
        `SPCE_OFS_SHUNT, `SPCE_OFS_RAIL, `SPCE_OFS_POWER, `SPCE_OFS_CURRENT: err_d = 1'b1;
        default: err_d = 1'b1; // unmapped here
      endcase
    end
    // Register reads return the full 16-bit word
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `SPCE_OFS_SETUP:   rdata_d = setup_q;
        `SPCE_OFS_SHUNT:   rdata_d = shunt_q;
        `SPCE_OFS_RAIL:    rdata_d = rail_q;
        `SPCE_OFS_POWER:   rdata_d = power_q;
        `SPCE_OFS_CURRENT: rdata_d = cur_q;
        `SPCE_OFS_SCALE:   rdata_d = scale_q;
        default: begin
          rdata_d = `SPCE_ZERO16;
          err_d   = 1'b1;
        end
      endcase
    end
    // Busy follows the next state so the output can come from a flip-flop
    busy_d = (st_d != SPCE_IDLE);
  end

  // Registers; power-on defaults give continuous conversions without setup
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q      <= SPCE_IDLE;
      setup_q   <= `SPCE_SETUP_RST;
      shunt_q   <= `SPCE_ZERO16;
      rail_q    <= `SPCE_ZERO16;
      power_q   <= `SPCE_ZERO16;
      cur_q     <= `SPCE_ZERO16;
      scale_q   <= `SPCE_ZERO16;
      rdata_q   <= `SPCE_ZERO16;
      err_q     <= 1'b0;
      restart_q <= 1'b0;
      neg_q     <= 1'b0;
      div_go_q  <= 1'b0;
      dvd_q     <= '0;
      busy_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      setup_q   <= setup_d;
      shunt_q   <= shunt_d;
      rail_q    <= rail_d;
      power_q   <= power_d;
      cur_q     <= cur_d;
      scale_q   <= scale_d;
      rdata_q   <= rdata_d;
      err_q     <= err_d;
      restart_q <= restart_d;
      neg_q     <= neg_d;
      div_go_q  <= div_go_d;
      dvd_q     <= dvd_d;
      busy_q    <= busy_d;
    end
  end

  // Outputs, all straight from flip-flops
  assign reg_rdata_out = rdata_q;
  assign reg_err_out   = err_q;
  assign setup_out     = setup_q;
  assign restart_out   = restart_q;
  assign busy_out      = busy_q;

  // ==========================================================
  // Checks
  // A calculation runs about 53 cycles from the bus conversion to the
  // power update: one cycle each for capture, current, operand load and divider
  // start, then 48 quotient steps and one cycle to land the saturated result.
  // A soft reset through the setup word may cut it short at any point.

  // Stored readings, results and their offsets
  chk_rail_msb_zero: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    rail_q[`SPCE_RAIL_MSB] == 1'b0)
    else $error("bus reading msb set");
  chk_rail_weight: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (rail_valid_in && !reg_wr_in) |=> rail_q == {1'b0, $past(rail_data_in[14:0])})
    else $error("bus reading altered");
  chk_rail_read: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (reg_rd_in && reg_addr_in == `SPCE_OFS_RAIL) |=> !reg_rdata_out[`SPCE_RAIL_MSB])
    else $error("bus reading read with msb set");
  chk_shunt_read: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (reg_rd_in && reg_addr_in == `SPCE_OFS_SHUNT) |=> reg_rdata_out == $past(shunt_q))
    else $error("shunt reading altered");
  chk_pwr_read: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (reg_rd_in && reg_addr_in == `SPCE_OFS_POWER) |=> reg_rdata_out == $past(power_q))
    else $error("power offset wrong");
  chk_cur_read: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (reg_rd_in && reg_addr_in == `SPCE_OFS_CURRENT) |=> reg_rdata_out == $past(cur_q))
    else $error("current offset wrong");

  // Results stay zero until a scale factor is present
  chk_cur_zero_uncal: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (scale_q == `SPCE_ZERO16 && $stable(scale_q)) |-> cur_q == `SPCE_ZERO16)
    else $error("current nonzero without scale factor");
  chk_pwr_zero_uncal: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (scale_q == `SPCE_ZERO16 && $stable(scale_q)) |-> power_q == `SPCE_ZERO16)
    else $error("power nonzero without scale factor");
  chk_scale_clear: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (reg_wr_in && reg_addr_in == `SPCE_OFS_SCALE && reg_wdata_in == `SPCE_ZERO16) |=>
      (cur_q == `SPCE_ZERO16 && power_q == `SPCE_ZERO16))
    else $error("results kept after scale cleared");

  // Arithmetic of both results
  chk_cur_formula: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st_q == SPCE_CUR && !reg_wr_in && scale_q != `SPCE_ZERO16) |=>
      cur_q == sat16($past(cur_shift)))
    else $error("current result wrong");
  chk_cur_sat: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st_q == SPCE_CUR && !reg_wr_in && scale_q != `SPCE_ZERO16 && cur_shift > `SPCE_SAT_MAX)
      |=> cur_q == `SPCE_SAT_HI16)
    else $error("current not saturated");
  chk_cur_lowsat: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st_q == SPCE_CUR && !reg_wr_in && scale_q != `SPCE_ZERO16 && cur_shift < `SPCE_SAT_MIN)
      |=> cur_q == `SPCE_SAT_LO16)
    else $error("current not saturated low");
  chk_pwr_formula: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st_q == SPCE_DONE && div_done && !reg_wr_in && scale_q != `SPCE_ZERO16) |=>
      power_q == sat16($past(pwr_signed)))
    else $error("power result wrong");
  chk_pwr_sat: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st_q == SPCE_DONE && div_done && !reg_wr_in && scale_q != `SPCE_ZERO16 &&
      pwr_signed > `SPCE_SAT_MAX) |=> power_q == `SPCE_SAT_HI16)
    else $error("power not saturated");
  chk_pwr_sign: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st_q == SPCE_DONE && div_done && !reg_wr_in && scale_q != `SPCE_ZERO16 &&
      neg_q && div_quot != '0) |=> power_q[15])
    else $error("negative power lost its sign");

  // Sequencing of one calculation
  chk_busy_start: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st_q == SPCE_IDLE && rail_valid_in && !reg_wr_in) |=> busy_out)
    else $error("calculation did not start");
  chk_calc_done: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st_q == SPCE_IDLE && rail_valid_in && !reg_wr_in) |-> ##[1:60] st_q == SPCE_IDLE)
    else $error("calculation did not finish");
  chk_div_finish: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(div_go_q) |-> ##[40:60] div_done)
    else $error("division did not finish");

  // Register port responses
  chk_ro_write_err: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (reg_wr_in && (reg_addr_in == `SPCE_OFS_POWER || reg_addr_in == `SPCE_OFS_CURRENT))
      |=> reg_err_out)
    else $error("write to result not refused");
  chk_err_quiet: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (!reg_wr_in && !reg_rd_in) |=> !reg_err_out)
    else $error("error without access");
  chk_restart_pulse: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (reg_wr_in && reg_addr_in == `SPCE_OFS_SETUP) |=> restart_out)
    else $error("setup write gave no restart");
  chk_restart_quiet: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    !(reg_wr_in && reg_addr_in == `SPCE_OFS_SETUP) |=> !restart_out)
    else $error("restart without setup write");
  chk_setup_fixed: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (setup_out[`SPCE_FIXED_BIT] && !setup_out[`SPCE_RST_BIT]))
    else $error("setup fixed bits wrong");
endmodule // spce_calc_engine

// ===== spce_divider.sv
`timescale 1ns/1ps
`include "spce_params.svh"
// ==========================================================
// Serial restoring divider, unsigned 48 by 48, one quotient bit per clock
module spce_divider
  import spce_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // Request
  input  wire logic        start_in,
  input  wire logic [47:0] dividend_in,
  input  wire logic [47:0] divisor_in,
  // Answer
  output logic             done_out,
  output logic [47:0]      quot_out
);
  logic [47:0] rem_q, rem_d, quo_q, quo_d;
  logic [5:0]  cnt_q, cnt_d;
  logic        busy_q, busy_d, done_q, done_d;
  logic [48:0] trial;

  // Next-state: shift one dividend bit in, subtract when it fits
  always_comb begin
    rem_d  = rem_q;
    quo_d  = quo_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    trial  = {rem_q, quo_q[47]} - {1'b0, divisor_in};
    if (start_in) begin
      rem_d  = '0;
      quo_d  = dividend_in;
      cnt_d  = `SPCE_DIV_STEPS;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (!trial[48]) begin
        rem_d = trial[47:0];
        quo_d = {quo_q[46:0], 1'b1};
      end else begin
        rem_d = {rem_q[46:0], quo_q[47]};
        quo_d = {quo_q[46:0], 1'b0};
      end
      cnt_d = cnt_q - 6'd1;
      if (cnt_q == 6'd1) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rem_q  <= '0;
      quo_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign done_out = done_q;
  assign quot_out = quo_q;
endmodule // spce_divider

// ===== spce_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host processor model on the engine's register port
module spce_host_model
  import spce_pkg::*;
(
  // Clock
  input  wire logic        ref_clk_in,
  // Register port toward the engine
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic [2:0]       reg_addr_out,
  output logic [15:0]      reg_wdata_out,
  input  wire logic [15:0] reg_rdata_in,
  input  wire logic        reg_err_in
);
  // Idle port at time zero
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 3'h7;
    reg_wdata_out = 16'hA5A5;
  end

  // One access, held over exactly one sampling edge; released address and data
  // lines show the inverse so a stale value never looks valid
  task automatic access(input logic wr, input logic [2:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic e);
    @(posedge ref_clk_in);
    #2;
    reg_wr_out = wr;
    reg_rd_out = !wr;
    reg_addr_out = a;
    reg_wdata_out = d;
    @(posedge ref_clk_in);
    #2;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
    q = reg_rdata_in;
    e = reg_err_in;
  endtask

  // Scale factor from current step (A) and shunt (ohm), rounded to nearest
  function automatic logic [15:0] scale_of(input real lsb, input real rsh);
    return 16'($rtoi(0.00512 / (lsb * rsh) + 0.5));
  endfunction

  // Correction from an external current measurement, truncated
  function automatic logic [15:0] corrected(input logic [15:0] cal, input int meas,
                                            input int rep);
    return 16'((longint'(cal) * meas) / rep);
  endfunction
endmodule // spce_host_model

// ===== spce_params.svh
`ifndef SPCE_PARAMS_SVH
`define SPCE_PARAMS_SVH
// ==========================================================
// Register offsets
`define SPCE_OFS_SETUP   3'h0
`define SPCE_OFS_SHUNT   3'h1
`define SPCE_OFS_RAIL    3'h2
`define SPCE_OFS_POWER   3'h3
`define SPCE_OFS_CURRENT 3'h4
`define SPCE_OFS_SCALE   3'h5
// ==========================================================
// Reset values and arithmetic constants
`define SPCE_SETUP_RST   16'h4127
`define SPCE_ZERO16      16'h0000
`define SPCE_CUR_SHIFT   11
`define SPCE_PWR_DIV     48'sd20000
`define SPCE_SAT_MAX     48'sh7FFF
`define SPCE_SAT_MIN     -48'sh8000
`define SPCE_SAT_HI16    16'h7FFF
`define SPCE_SAT_LO16    16'h8000
`define SPCE_RST_BIT     15
`define SPCE_FIXED_BIT   14
`define SPCE_RAIL_MSB    15
`define SPCE_DIV_STEPS   6'd48
`endif

// ===== spce_pkg.sv
package spce_pkg;
  typedef enum logic [3:0] {
    SPCE_IDLE = 4'b0001,
    SPCE_CUR  = 4'b0010,
    SPCE_DIV  = 4'b0100,
    SPCE_DONE = 4'b1000
  } spce_state_t;
  typedef logic [15:0] spce_word_t;
endpackage
